// *** verilog/scc_pkg.sv ***
// Package: configuration register layout, frame layout and timing for the star coupler config block
package scc_pkg;

  // Frame layout on the 16-bit serial host word
  localparam int FRAME_W          = 16;
  localparam int DATA_W           = 12;
  localparam int ADDR_W           = 3;
  localparam int BRANCHES         = 4;

  // Register addresses (frame bits 15..13)
  localparam logic [2:0] ADDR_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_GENERAL   = 3'h2;
  localparam logic [2:0] ADDR_BRANCH1   = 3'h3;
  localparam logic [2:0] ADDR_BRANCH4   = 3'h6;
  localparam logic [2:0] ADDR_CONFIG    = 3'h7;

  // Configuration field positions
  localparam int POS_AUTO_CONFINE  = 11;
  localparam int POS_GLITCH_TIMER  = 10;
  localparam int POS_WAKE_HI       = 9;
  localparam int POS_WAKE_LO       = 6;
  localparam int POS_CC_IF         = 5;
  localparam int POS_CASCADE       = 4;
  localparam int POS_RESERVED      = 3;
  localparam int POS_CLAMP         = 2;
  localparam int POS_LATCH         = 1;
  localparam int POS_PARITY        = 0;

  // Field reset values
  localparam logic       RST_AUTO_CONFINE = 1'h0;
  localparam logic       RST_GLITCH_TIMER = 1'h1;
  localparam logic [3:0] RST_WAKE         = 4'hF;
  localparam logic       RST_CC_IF        = 1'h0;
  localparam logic       RST_CASCADE      = 1'h1;
  localparam logic       RST_CLAMP        = 1'h1;
  localparam logic       RST_LATCH        = 1'h0;

  // Glitch reject timeout and its cycle count at 100 MHz (least time, rounded up)
  localparam int CLK_PERIOD_NS         = 10;
  localparam int GLITCH_REJECT_TIMEOUT_NS = 2000;
  localparam int GLITCH_CYCLES =
    (GLITCH_REJECT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (GLITCH_REJECT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CNT_W  = 9;
  localparam logic [GLITCH_CNT_W-1:0] GLITCH_LAST = GLITCH_CNT_W'(GLITCH_CYCLES - 1);

  // One serial frame as delivered by the shift engine
  typedef struct packed {
    logic [2:0]  addr;
    logic        read_only;
    logic [11:0] data;
  } scc_frame_type;

  // Writable configuration fields
  typedef struct packed {
    logic       autonomous_error_confine_en;
    logic       bus_failure_glitch_timer_en;
    logic [3:0] branch_wakeup_detect_en;     // [3] = branch 1 .. [0] = branch 4
    logic       comm_controller_if_en;
    logic       cascade_link_en;
    logic       clamp_monitor_en;
    logic       status_latch_en;
  } scc_cfg_type;

  localparam scc_cfg_type CFG_RESET = '{RST_AUTO_CONFINE, RST_GLITCH_TIMER, RST_WAKE,
                                        RST_CC_IF, RST_CASCADE, RST_CLAMP, RST_LATCH};

endpackage

// *** verilog/scc_config_reg.sv ***
// Configuration register of the four-branch star coupler and the logic it steers
`timescale 1ns/1ns

module scc_config_reg (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST,
  input  wire logic                       FRAME_STROBE,
  input  wire scc_pkg::scc_frame_type     FRAME_WORD,
  output logic                            READ_VALID,
  output logic [15:0]                     READ_WORD,
  output scc_pkg::scc_cfg_type            CFG,
  input  wire logic [3:0]                 BRANCH_TX_FAULT_RAW,
  input  wire logic [3:0]                 BRANCH_WAKE_RAW,
  input  wire logic                       CC_TRANSMIT_ENABLE_IN_PIN,
  input  wire logic                       CLAMP_ON_TX_ENABLE_FLAG_RAW,
  input  wire logic                       CLAMP_CASCADE_RAW,
  input  wire logic [3:0]                 CLAMP_BRANCH_RAW,
  input  wire logic                       RXD_DATA,
  input  wire logic [11:0]                GEN_STATUS_LIVE,
  input  wire logic [47:0]                BRANCH_STATUS_LIVE,
  output logic [3:0]                      BRANCH_BUS_ERROR,
  output logic [3:0]                      BRANCH_SILENCE_REQ,
  output logic [3:0]                      BRANCH_WAKEUP,
  output logic                            CC_TX_ENABLE,
  output logic                            RXD_OUT,
  output logic                            RXD_OE,
  output logic                            CASCADE_LINK_ENABLE,
  output logic                            CLAMP_ON_TX_ENABLE_FLAG,
  output logic                            CLAMP_ON_CASCADE_FLAG,
  output logic [3:0]                      CLAMP_ON_BRANCH_FLAG,
  output logic                            CLAMP_ERROR_IRQ,
  output logic [11:0]                     GEN_STATUS_VIEW,
  output logic [47:0]                     BRANCH_STATUS_VIEW
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Packs the configuration into the 12-bit readback with odd parity in bit 0
  function automatic logic [11:0] cfg_word(input scc_pkg::scc_cfg_type c);
    logic [11:0] w;
    w = 12'h000;
    w[scc_pkg::POS_AUTO_CONFINE]                    = c.autonomous_error_confine_en;
    w[scc_pkg::POS_GLITCH_TIMER]                    = c.bus_failure_glitch_timer_en;
    w[scc_pkg::POS_WAKE_HI:scc_pkg::POS_WAKE_LO]    = c.branch_wakeup_detect_en;
    w[scc_pkg::POS_CC_IF]                           = c.comm_controller_if_en;
    w[scc_pkg::POS_CASCADE]                         = c.cascade_link_en;
    w[scc_pkg::POS_RESERVED]                        = 1'h0;
    w[scc_pkg::POS_CLAMP]                           = c.clamp_monitor_en;
    w[scc_pkg::POS_LATCH]                           = c.status_latch_en;
    w[scc_pkg::POS_PARITY]                          = ~(^w[11:1]);
    return w;
  endfunction

  // Status view: held value while latching, live value otherwise
  function automatic logic [11:0] status_pick(input logic en, input logic [11:0] held,
                                              input logic [11:0] live);
    return en ? held : live;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode

  logic        cfg_hit;
  logic        cfg_write;
  logic        gen_read;
  logic [3:0]  branch_read;

  // Address and access decode of each frame
  always_comb begin
    cfg_hit   = FRAME_STROBE && (FRAME_WORD.addr == scc_pkg::ADDR_CONFIG);
    cfg_write = cfg_hit && !FRAME_WORD.read_only;
    gen_read  = FRAME_STROBE && (FRAME_WORD.addr == scc_pkg::ADDR_GENERAL);
    for (int b = 0; b < scc_pkg::BRANCHES; b++) begin
      branch_read[b] = FRAME_STROBE && (FRAME_WORD.addr == 3'(scc_pkg::ADDR_BRANCH1 + 3'(b)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  scc_pkg::scc_cfg_type cfg;
  scc_pkg::scc_cfg_type next_cfg;
  logic [11:0]          cfg_now;

  // Write path; reserved and parity bits are not stored
  always_comb begin
    next_cfg = cfg;
    if (cfg_write) begin
      next_cfg.autonomous_error_confine_en = FRAME_WORD.data[scc_pkg::POS_AUTO_CONFINE];
      next_cfg.bus_failure_glitch_timer_en = FRAME_WORD.data[scc_pkg::POS_GLITCH_TIMER];
      next_cfg.branch_wakeup_detect_en     = FRAME_WORD.data[scc_pkg::POS_WAKE_HI:scc_pkg::POS_WAKE_LO];
      next_cfg.comm_controller_if_en       = FRAME_WORD.data[scc_pkg::POS_CC_IF];
      next_cfg.cascade_link_en             = FRAME_WORD.data[scc_pkg::POS_CASCADE];
      next_cfg.clamp_monitor_en            = FRAME_WORD.data[scc_pkg::POS_CLAMP];
      next_cfg.status_latch_en             = FRAME_WORD.data[scc_pkg::POS_LATCH];
    end
  end

  // Register with field defaults at reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cfg <= scc_pkg::CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign CFG = cfg;
  assign cfg_now = cfg_word(cfg);

  // Readback of the contents shifted out during the frame, before any write
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      READ_VALID <= 1'h0;
      READ_WORD  <= 16'h0000;
    end else begin
      READ_VALID <= cfg_hit;
      if (cfg_hit) begin
        READ_WORD <= {scc_pkg::ADDR_CONFIG, FRAME_WORD.read_only, cfg_now};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int SYNC_W = 15;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  // Two flops on every pin-side input
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sync_a <= 15'h0000;
      sync_b <= 15'h0000;
    end else begin
      sync_a <= {BRANCH_TX_FAULT_RAW, BRANCH_WAKE_RAW, CC_TRANSMIT_ENABLE_IN_PIN, CLAMP_ON_TX_ENABLE_FLAG_RAW,
                 CLAMP_CASCADE_RAW, CLAMP_BRANCH_RAW};
      sync_b <= sync_a;
    end
  end

  logic [3:0] tx_fault_s;
  logic [3:0] wake_s;
  logic       cc_transmit_enable_in_s;
  logic       clamp_on_tx_enable_flag_s;
  logic       clamp_cascade_s;
  logic [3:0] clamp_branch_s;

  assign {tx_fault_s, wake_s, cc_transmit_enable_in_s, clamp_on_tx_enable_flag_s, clamp_cascade_s, clamp_branch_s} = sync_b;

  ////////////////////////////////////////////////////////////////////////////
  // Bus error glitch rejection and error confinement

  logic [scc_pkg::GLITCH_CNT_W-1:0] glitch_cnt [4];

  // Fault must persist the full timeout while the timer is on
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      for (int b = 0; b < 4; b++) begin
        glitch_cnt[b] <= '0;
      end
      BRANCH_BUS_ERROR <= 4'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (!tx_fault_s[b]) begin
          glitch_cnt[b]       <= '0;
          BRANCH_BUS_ERROR[b] <= 1'h0;
        end else if (!cfg.bus_failure_glitch_timer_en) begin
          BRANCH_BUS_ERROR[b] <= 1'h1;
        end else if (glitch_cnt[b] == scc_pkg::GLITCH_LAST) begin
          BRANCH_BUS_ERROR[b] <= 1'h1;
        end else begin
          glitch_cnt[b] <= glitch_cnt[b] + 1'b1;
        end
      end
    end
  end

  // Silence request to the branch state machines
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BRANCH_SILENCE_REQ <= 4'h0;
    end else begin
      BRANCH_SILENCE_REQ <= BRANCH_BUS_ERROR & {4{cfg.autonomous_error_confine_en}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up, controller interface and cascade enables

  // Per-branch wake-up gating; bit 3 of the field is branch 1
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BRANCH_WAKEUP <= 4'h0;
    end else begin
      BRANCH_WAKEUP <= wake_s & cfg.branch_wakeup_detect_en;
    end
  end

  // Controller interface: transmit enable gated, receive driver off when disabled
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CC_TX_ENABLE <= 1'h0;
      RXD_OUT      <= 1'h1;
    end else begin
      CC_TX_ENABLE <= cc_transmit_enable_in_s & cfg.comm_controller_if_en;
      RXD_OUT      <= RXD_DATA;
    end
  end

  assign RXD_OE              = cfg.comm_controller_if_en;
  assign CASCADE_LINK_ENABLE = cfg.cascade_link_en;

  ////////////////////////////////////////////////////////////////////////////
  // Clamp monitoring

  // Clamp flags and interrupt level, all gated by the monitor enable
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CLAMP_ON_TX_ENABLE_FLAG <= 1'h0;
      CLAMP_ON_CASCADE_FLAG   <= 1'h0;
      CLAMP_ON_BRANCH_FLAG    <= 4'h0;
      CLAMP_ERROR_IRQ         <= 1'h0;
    end else begin
      CLAMP_ON_TX_ENABLE_FLAG <= clamp_on_tx_enable_flag_s & cfg.clamp_monitor_en;
      CLAMP_ON_CASCADE_FLAG   <= clamp_cascade_s & cfg.clamp_monitor_en & cfg.cascade_link_en;
      CLAMP_ON_BRANCH_FLAG    <= clamp_branch_s & {4{cfg.clamp_monitor_en}};
      CLAMP_ERROR_IRQ         <= cfg.clamp_monitor_en &&
                                 (clamp_on_tx_enable_flag_s || (clamp_cascade_s && cfg.cascade_link_en) ||
                                  (|clamp_branch_s));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bit latching

  logic [11:0] gen_held;
  logic [47:0] branch_held;

  // Held copies accumulate events; a read reloads the live value
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      gen_held    <= 12'h000;
      branch_held <= 48'h000000000000;
    end else begin
      if (!cfg.status_latch_en || gen_read) begin
        gen_held <= GEN_STATUS_LIVE;
      end else begin
        gen_held <= gen_held | GEN_STATUS_LIVE;
      end
      for (int b = 0; b < 4; b++) begin
        if (!cfg.status_latch_en || branch_read[b]) begin
          branch_held[b*12 +: 12] <= BRANCH_STATUS_LIVE[b*12 +: 12];
        end else begin
          branch_held[b*12 +: 12] <= branch_held[b*12 +: 12] | BRANCH_STATUS_LIVE[b*12 +: 12];
        end
      end
    end
  end

  // Presented status: live when latching is off, held copy while latching
  always_comb begin
    GEN_STATUS_VIEW = status_pick(cfg.status_latch_en, gen_held, GEN_STATUS_LIVE);
    for (int b = 0; b < 4; b++) begin
      BRANCH_STATUS_VIEW[b*12 +: 12] = status_pick(cfg.status_latch_en, branch_held[b*12 +: 12],
                                                   BRANCH_STATUS_LIVE[b*12 +: 12]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_cfg_write;
    FRAME_STROBE && FRAME_WORD.addr == 3'h7 && !FRAME_WORD.read_only;
  endsequence

  sequence s_cfg_read;
    FRAME_STROBE && FRAME_WORD.addr == 3'h7;
  endsequence

  AST_WRITE_STORES: assert property (s_cfg_write |=> (cfg_now[11:1] & 11'h7FB) ==
                                     ($past(FRAME_WORD.data[11:1]) & 11'h7FB))
    else $error("config write not stored");
  AST_READ_ONLY_KEEPS: assert property (FRAME_STROBE && FRAME_WORD.read_only |=> $stable(cfg))
    else $error("read-only frame changed config");
  AST_OTHER_ADDR_KEEPS: assert property (FRAME_STROBE && FRAME_WORD.addr != 3'h7 |=> $stable(cfg))
    else $error("other address changed config");
  AST_READ_PARITY: assert property (s_cfg_read |=> READ_VALID && ^READ_WORD[11:0] == 1'b1
                                    && READ_WORD[3] == 1'b0)
    else $error("readback parity or reserved bit wrong");
  AST_RXD_DRIVER: assert property (s_cfg_write |=> RXD_OE == $past(FRAME_WORD.data[scc_pkg::POS_CC_IF]))
    else $error("receive driver enable mismatch");
  AST_SILENCE: assert property (BRANCH_BUS_ERROR[0] && cfg.autonomous_error_confine_en
                                && $stable(cfg) |=> BRANCH_SILENCE_REQ[0])
    else $error("silence request missing");
  AST_NO_SILENCE: assert property (!cfg.autonomous_error_confine_en |=> BRANCH_SILENCE_REQ == 4'h0)
    else $error("silence without confinement enable");
  AST_GLITCH_REJECT: assert property (cfg.bus_failure_glitch_timer_en && !tx_fault_s[0]
                                      ##1 cfg.bus_failure_glitch_timer_en && tx_fault_s[0]
                                      |-> (!BRANCH_BUS_ERROR[0]) [*3])
    else $error("short fault pulse not rejected");
  AST_CLAMP_OFF: assert property (!cfg.clamp_monitor_en |=> !CLAMP_ERROR_IRQ)
    else $error("clamp irq while monitor off");
  AST_CLAMP_IRQ: assert property (cfg.clamp_monitor_en && clamp_on_tx_enable_flag_s && $stable(cfg) |=> CLAMP_ERROR_IRQ)
    else $error("clamp irq missing");
  AST_LIVE_WHEN_OFF: assert property (!cfg.status_latch_en |-> GEN_STATUS_VIEW == GEN_STATUS_LIVE)
    else $error("status not live with latching off");
  AST_LATCH_HOLDS: assert property (cfg.status_latch_en && $past(cfg.status_latch_en) && !$past(gen_read)
                                    |-> (GEN_STATUS_VIEW & $past(GEN_STATUS_VIEW)) == $past(GEN_STATUS_VIEW))
    else $error("latched status bit dropped");
  AST_LATCH_RELEASE: assert property (cfg.status_latch_en && gen_read && $stable(cfg)
                                      |=> GEN_STATUS_VIEW == $past(GEN_STATUS_LIVE))
    else $error("read did not release latch");
  AST_WAKE_GATE: assert property (cfg.branch_wakeup_detect_en == 4'h0 |=> BRANCH_WAKEUP == 4'h0)
    else $error("wake-up seen while detection off");

endmodule // scc_config_reg

// *** verilog/scc_unused_placeholder_removed.sv ***
// Intentionally empty design unit list: no further logic
`timescale 1ns/1ns

// *** sim/scc_host_model.sv ***
// Host model issuing whole 16-bit register frames to the configuration block
`timescale 1ns/1ns

module scc_host_model (
  input  wire logic              SYS_CLK,
  input  wire logic              READ_VALID,
  input  wire logic [15:0]       READ_WORD,
  output scc_pkg::scc_frame_type FRAME_WORD,
  output logic                   FRAME_STROBE
);

  // Idle bus at time zero
  initial begin
    FRAME_STROBE = 1'h0;
    FRAME_WORD   = '0;
  end

  // One frame after an idle gap; answer taken once the taking edge has settled
  task automatic xfer(input logic [2:0] addr, input logic ro, input logic [11:0] data, input int gap,
                      output logic rvalid, output logic [15:0] rword);
    repeat (gap + 1) @(posedge SYS_CLK);
    FRAME_STROBE <= 1'h1;
    FRAME_WORD   <= '{addr, ro, data};
    @(posedge SYS_CLK);
    FRAME_STROBE <= 1'h0;
    FRAME_WORD   <= scc_pkg::scc_frame_type'(~{addr, ro, data}); // Released word is not left stale
    #1;
    rvalid = READ_VALID;
    rword  = READ_WORD;
  endtask

endmodule // scc_host_model

// *** sim/tb.sv ***
// Self-checking testbench for the star coupler configuration register
`timescale 1ns/1ns

module tb;
  logic                  sys_clk, rst, rxd_data, cc_transmit_enable_in_pin, clamp_on_tx_enable_flag_raw, clamp_cascade_raw, rv, seen_err, watch_clr;
  logic                  read_valid, rxd_out, rxd_oe, cc_tx, cascade_en, clamp_tx_flag, clamp_cas_flag, irq;
  logic [3:0]            fault_raw, wake_raw, clamp_br_raw, bus_err, silence, wakeup, clamp_br_flag;
  logic [11:0]           gen_live, gen_view;
  logic [47:0]           br_live, br_view;
  logic [15:0]           read_word, rd_word;
  logic                  strobe;
  scc_pkg::scc_frame_type frame;
  scc_pkg::scc_cfg_type  cfg, model_cfg;
  int                    checked, bad_count;
  logic [11:0]           pats [5] = '{12'hFFF, 12'h000, 12'hA5A, 12'h5A5, 12'h7FF};

  scc_host_model host_u (.SYS_CLK(sys_clk), .READ_VALID(read_valid), .READ_WORD(read_word),
                         .FRAME_WORD(frame), .FRAME_STROBE(strobe));

  scc_config_reg dut_u (
    .SYS_CLK(sys_clk), .RST(rst), .FRAME_STROBE(strobe), .FRAME_WORD(frame), .READ_VALID(read_valid),
    .READ_WORD(read_word), .CFG(cfg), .BRANCH_TX_FAULT_RAW(fault_raw), .BRANCH_WAKE_RAW(wake_raw),
    .CC_TRANSMIT_ENABLE_IN_PIN(cc_transmit_enable_in_pin), .CLAMP_ON_TX_ENABLE_FLAG_RAW(clamp_on_tx_enable_flag_raw), .CLAMP_CASCADE_RAW(clamp_cascade_raw),
    .CLAMP_BRANCH_RAW(clamp_br_raw), .RXD_DATA(rxd_data), .GEN_STATUS_LIVE(gen_live),
    .BRANCH_STATUS_LIVE(br_live), .BRANCH_BUS_ERROR(bus_err), .BRANCH_SILENCE_REQ(silence),
    .BRANCH_WAKEUP(wakeup), .CC_TX_ENABLE(cc_tx), .RXD_OUT(rxd_out), .RXD_OE(rxd_oe),
    .CASCADE_LINK_ENABLE(cascade_en), .CLAMP_ON_TX_ENABLE_FLAG(clamp_tx_flag),
    .CLAMP_ON_CASCADE_FLAG(clamp_cas_flag), .CLAMP_ON_BRANCH_FLAG(clamp_br_flag),
    .CLAMP_ERROR_IRQ(irq), .GEN_STATUS_VIEW(gen_view), .BRANCH_STATUS_VIEW(br_view));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, error watcher and watchdog
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) seen_err <= watch_clr ? 1'h0 : (seen_err | bus_err[0]);

  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register word the host should see, parity odd over the 12 data bits
  function automatic logic [11:0] word_of(input scc_pkg::scc_cfg_type c);
    logic [11:0] w;
    w = {c.autonomous_error_confine_en, c.bus_failure_glitch_timer_en, c.branch_wakeup_detect_en,
         c.comm_controller_if_en, c.cascade_link_en, 1'h0, c.clamp_monitor_en, c.status_latch_en, 1'h0};
    w[0] = ~^w[11:1];
    return w;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Frame access with readback and contents checks
  task automatic wr(input logic [2:0] a, input logic ro, input logic [11:0] d);
    host_u.xfer(a, ro, d, 0, rv, rd_word);
    if (a == 3'h7) begin
      check("read_valid", 48'(rv), 48'h1);
      check("read_word", 48'(rd_word), 48'({3'h7, ro, word_of(model_cfg)}));
      if (!ro) model_cfg = '{d[11], d[10], d[9:6], d[5], d[4], d[2], d[1]};
    end else begin
      check("read_valid_other", 48'(rv), 48'h0);
    end
    check("cfg", 48'(cfg), 48'(model_cfg));
  endtask

  task automatic test_done();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'h1; rxd_data = 1'h0; cc_transmit_enable_in_pin = 1'h0; clamp_on_tx_enable_flag_raw = 1'h0; clamp_cascade_raw = 1'h0;
    fault_raw = 4'h0; wake_raw = 4'h0; clamp_br_raw = 4'h0; gen_live = 12'h000; br_live = 48'h0;
    watch_clr = 1'h1; checked = 0; bad_count = 0; model_cfg = scc_pkg::CFG_RESET;
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    cyc(1);
    check("cfg_reset", 48'(cfg), 48'(scc_pkg::CFG_RESET));
    check("rxd_oe_reset", 48'(rxd_oe), 48'h0);
    check("cascade_reset", 48'(cascade_en), 48'h1);
    wr(3'h7, 1'h1, 12'h000);
    check("reset_word", 48'(rd_word[11:0]), 48'h7D4);
    // Write patterns, reserved and parity bits set among them
    foreach (pats[i]) wr(3'h7, 1'h0, pats[i]);
    wr(3'h7, 1'h1, 12'h000);
    check("reserved_parity", 48'({rd_word[3], ^rd_word[11:0]}), 48'h1);
    // Other addresses never touch the register
    for (int a = 0; a < 7; a++) wr(3'(a), 1'h0, 12'h000);
    // Error confinement with glitch timer off
    wr(3'h7, 1'h0, 12'h800);
    fault_raw <= 4'h1;
    cyc(6);
    check("bus_err_aec", 48'(bus_err), 48'h1);
    check("silence_aec", 48'(silence), 48'h1);
    fault_raw <= 4'h0;
    wr(3'h7, 1'h0, 12'h000);
    fault_raw <= 4'h1;
    cyc(6);
    check("silence_off", 48'(silence), 48'h0);
    fault_raw <= 4'h0;
    // Glitch timer: short pulse rejected, long one seen
    wr(3'h7, 1'h0, 12'h400);
    cyc(6);
    watch_clr <= 1'h0;
    fault_raw <= 4'h1;
    cyc(150);
    fault_raw <= 4'h0;
    cyc(6);
    check("glitch_short", 48'(seen_err), 48'h0);
    fault_raw <= 4'h1;
    cyc(210);
    check("glitch_long", 48'(bus_err), 48'h1);
    fault_raw <= 4'h0;
    // Per-branch wake enables, branches 1 and 3 only
    wr(3'h7, 1'h0, 12'h280);
    wake_raw <= 4'hF;
    cyc(5);
    check("wakeup", 48'(wakeup), 48'hA);
    wake_raw <= 4'h0;
    // Controller interface on, cascade off, then the reverse
    wr(3'h7, 1'h0, 12'h020);
    cc_transmit_enable_in_pin <= 1'h1;
    rxd_data <= 1'h1;
    cyc(5);
    check("cc_tx_on", 48'({cc_tx, rxd_oe, rxd_out, cascade_en}), 48'hE);
    wr(3'h7, 1'h0, 12'h010);
    cyc(5);
    check("cc_tx_off", 48'({cc_tx, rxd_oe, cascade_en}), 48'h1);
    cc_transmit_enable_in_pin <= 1'h0;
    // Clamp monitoring on and off
    wr(3'h7, 1'h0, 12'h014);
    clamp_on_tx_enable_flag_raw <= 1'h1;
    clamp_cascade_raw <= 1'h1;
    clamp_br_raw <= 4'h9;
    cyc(5);
    check("clamp_on", 48'({clamp_tx_flag, clamp_cas_flag, clamp_br_flag, irq}), 48'h73);
    wr(3'h7, 1'h0, 12'h010);
    cyc(5);
    check("clamp_off", 48'({clamp_tx_flag, clamp_cas_flag, clamp_br_flag, irq}), 48'h0);
    clamp_on_tx_enable_flag_raw <= 1'h0;
    clamp_cascade_raw <= 1'h0;
    clamp_br_raw <= 4'h0;
    // Status latching off: live only
    wr(3'h7, 1'h0, 12'h000);
    gen_live <= 12'h004;
    cyc(1);
    check("live_view_on", 48'(gen_view), 48'h004);
    gen_live <= 12'h000;
    cyc(3);
    check("live_view", 48'(gen_view), 48'h0);
    // Status latching on: held until the owning register is read
    wr(3'h7, 1'h0, 12'h002);
    gen_live <= 12'h004;
    br_live <= 48'h800000000030;
    cyc(1);
    gen_live <= 12'h000;
    br_live <= 48'h0;
    cyc(3);
    check("gen_held", 48'(gen_view), 48'h004);
    check("br_held", br_view, 48'h800000000030);
    wr(3'h2, 1'h1, 12'h000);
    cyc(1);
    check("gen_released", 48'(gen_view), 48'h0);
    check("br_still_held", br_view, 48'h800000000030);
    wr(3'h3, 1'h1, 12'h000);
    cyc(1);
    check("br1_released", br_view, 48'h800000000000);
    // Second reset in mid-run
    rst <= 1'h1;
    cyc(2);
    rst <= 1'h0;
    cyc(1);
    model_cfg = scc_pkg::CFG_RESET;
    check("cfg_rereset", 48'(cfg), 48'(scc_pkg::CFG_RESET));
    wr(3'h7, 1'h1, 12'h000);
    test_done();
  end

endmodule // tb
